// >>> bench/incr_core_assertions.sv
module incr_core_checker (
	// Clock and reset
	input wire        pclk,
	input wire        presetn,
	input wire        ce,
	// Bus
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [7:0]  paddr,
	input wire        pready,
	input wire        pslverr,
	input wire [31:0] prdata,
	// Core
	input wire        busy,
	input wire        skip_taken
);
	timeunit 1ns;
	timeprecision 1ns;
	reg  [3:0] busy_cnt;
	wire       start;
	// Instruction register write completes
	assign start = psel && penable && pready && pwrite && paddr == 8'h10;
	// Enabled busy cycles; ce low stalls the core, so only ce-high edges count
	always @(posedge pclk or negedge presetn)
		if (!presetn)
			busy_cnt <= 4'h0;
		else if (!busy)
			busy_cnt <= 4'h0;
		else if (ce)
			busy_cnt <= busy_cnt + 4'h1;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	busy_rise_a: assert property (start && !busy |=> busy)
		else $error("busy did not follow an instruction write");
	busy_cause_a: assert property ($rose(busy) |-> $past(start))
		else $error("busy rose without an instruction write");
	plain_len_a: assert property ($fell(busy) && !skip_taken |-> busy_cnt inside {1, 4})
		else $error("run without skip has wrong length");
	skip_len_a: assert property ($fell(busy) && skip_taken |-> busy_cnt inside {8, 12})
		else $error("skipping run has wrong length");
	skip_phase_a: assert property ($rose(skip_taken) |-> busy && busy_cnt == 4)
		else $error("skip flagged outside the write phase");
	bus_ready_a: assert property (psel && !penable && ce ##1 penable && ce |-> pready)
		else $error("no zero wait answer");
	bus_err_a: assert property (pslverr |-> pready)
		else $error("error without ready");
	stat_read_a: assert property (psel && !penable && ce && !pwrite && paddr == 8'h14
		##1 pready |-> prdata[0] == $past(busy) && prdata[1] == $past(skip_taken))
		else $error("status read does not match core state");
	reset_idle_a: assert property ($rose(presetn) |-> !busy && !skip_taken)
		else $error("core not idle after reset");
	cover property ($fell(busy) && busy_cnt == 12);
	cover property ($fell(busy) && !skip_taken);
	cover property (pslverr);
endmodule

bind incr_core incr_core_checker chk_u (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
	.paddr, .pready, .pslverr, .prdata, .busy, .skip_taken);

// >>> bench/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	// Design ports
	logic        pclk = 0;
	logic        presetn = 0;
	logic        ce = 1;
	logic        psel = 0;
	logic        penable = 0;
	logic        pwrite = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	wire         pready;
	wire         pslverr;
	wire  [31:0] prdata;
	wire         busy;
	wire         skip_taken;
	// Model state
	int          n_errors = 0;
	int          tests_run = 0;
	int          k;
	logic        ce_rand = 0;
	logic        er, d, a, ext, tw, skp;
	logic [31:0] rd;
	logic [7:0]  f, v, w, res;
	logic [3:0]  bk;
	logic [11:0] ix, ea;
	logic [4:0]  fl, efl;
	logic [15:0] op;
	logic [1:0]  cyc;

	incr_core dut_u (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pready, .pslverr, .prdata, .busy, .skip_taken);

	// 10 MHz clock
	always #50 pclk = ~pclk;

	// Random stalls once enabled
	always @(posedge pclk)
		ce <= ce_rand ? ($urandom % 8 != 0) : 1'h1;

	// Compare one result
	task chk(input [31:0] got, input [31:0] exp);
		tests_run++;
		if (got !== exp)
			$display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
		if (got !== exp)
			n_errors++;
	endtask

	// Bus transfer, request held until pready is seen
	task apb(input bit wr, input [7:0] ad, input [31:0] wd);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1;
		do
			@(posedge pclk);
		while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	task print_verdict;
		$display("errors %0d checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Run needs about 3000 cycles; cut a hang well beyond that
	initial
	begin
		#5000000;
		n_errors++;
		print_verdict;
	end

	initial
	begin
		void'($urandom(94810));
		repeat (4) @(posedge pclk);
		presetn <= 1;
		// Reset values, unmapped place, read-only status
		for (int j = 0; j < 8; j++)
			if (j != 4)
			begin
				apb(0, 8'(j * 4), 0);
				chk(rd, 0);
			end
		apb(1, 8'h24, 32'hff);
		apb(0, 8'h24, 0);
		chk({rd[30:0], er}, 1);
		apb(1, 8'h14, 32'h3f);
		apb(0, 8'h14, 0);
		chk(rd, 0);
		// Unknown opcode stops after decode and flags itself
		apb(1, 8'h10, 32'h0);
		#1;
		while (busy !== 1'h0)
			@(posedge pclk) #1;
		apb(0, 8'h14, 0);
		chk(rd & 32'h37, 32'h04);
		for (int i = 0; i < 60; i++)
		begin
			ce_rand = i >= 30;
			k = i % 3;
			{d, a, ext, tw, bk, f, w, fl} = $urandom;
			ix = $urandom;
			v = i % 4 == 0 ? 8'hff : i % 4 == 1 ? 8'h7f : i % 4 == 2 ? 8'h0f : $urandom;
			ea = a ? {bk, f} : (ext && f <= 8'h5f) ? ix + f : f <= 8'h5f ? {4'h0, f} : {4'hf, f};
			res = v + 8'h01;
			op = {k == 0 ? 6'h0a : k == 1 ? 6'h0f : 6'h12, d, a, f};
			skp = k == 1 ? res == 0 : k == 2 ? res != 0 : 0;
			efl = k == 0 ? {res[7], v == 8'h7f, res == 0, v[3:0] == 4'hf, v == 8'hff} : fl;
			cyc = skp ? (tw ? 2'h3 : 2'h2) : 2'h1;
			apb(1, 8'h00, 32'({tw, ext}));
			apb(1, 8'h04, 32'(bk));
			apb(1, 8'h18, 32'(ix));
			apb(1, 8'h08, 32'(w));
			apb(1, 8'h0c, 32'(fl));
			apb(1, 8'h1c, 32'(ea));
			apb(1, 8'h20, 32'(v));
			apb(1, 8'h10, 32'(op));
			// Write while busy must leave W alone
			apb(1, 8'h08, 32'h55);
			#1;
			while (busy !== 1'h0)
				@(posedge pclk) #1;
			chk(32'(skip_taken), 32'(skp));
			apb(0, 8'h14, 0);
			chk(rd & 32'h33, 32'({cyc, 2'h0, skp, 1'h0}));
			apb(0, 8'h08, 0);
			chk(rd, 32'(d ? w : res));
			apb(0, 8'h0c, 0);
			chk(rd, 32'(efl));
			apb(0, 8'h20, 0);
			chk(rd, 32'(d ? res : v));
		end
		print_verdict;
	end
endmodule

// >>> logic/incr_alu.v
`include "incr_core_map.vh"

module incr_alu (
	// Operand
	input  wire [7:0] operand,
	// Result and flags
	output wire [7:0] result,
	output wire [4:0] flags
);

	wire [8:0] sum;
	wire [4:0] low_sum;

	// Add one, carries from both nibbles
	assign sum     = {1'b0, operand} + 9'h001;
	assign low_sum = {1'b0, operand[3:0]} + 5'h01;
	assign result  = sum[7:0];

	// Overflow only when a positive value wraps to negative
	assign flags[`FLAG_C_BIT]  = sum[8];
	assign flags[`FLAG_DIGIT_BIT] = low_sum[4];
	assign flags[`FLAG_Z_BIT]  = (sum[7:0] == 8'h00);
	assign flags[`FLAG_OVF_BIT] = ~operand[7] & sum[7];
	assign flags[`FLAG_N_BIT]  = sum[7];

endmodule

// >>> logic/incr_core.v
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`include "incr_core_map.vh"

module incr_core (
	// Clock, reset, enable
	input  wire        pclk,
	input  wire        presetn,
	input  wire        ce,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output wire        pslverr,
	output wire [31:0] prdata,
	// Core status
	output wire        busy,
	output wire        skip_taken
);

	// One-hot phase states
	localparam [5:0] ST_IDLE = 6'h01;
	localparam [5:0] ST_Q1   = 6'h02;
	localparam [5:0] ST_Q2   = 6'h04;
	localparam [5:0] ST_Q3   = 6'h08;
	localparam [5:0] ST_Q4   = 6'h10;
	localparam [5:0] ST_NOP  = 6'h20;

	reg  [7:0]  mem [0:`MEM_DEPTH-1];
	reg  [5:0]  state_reg;
	reg  [1:0]  nop_phase_reg;
	reg  [1:0]  nops_left_reg;
	reg  [1:0]  ctrl_reg;
	reg  [3:0]  bank_select_register;
	reg  [7:0]  wreg_reg;
	reg  [4:0]  flags_reg;
	reg  [15:0] instr_reg;
	reg  [11:0] index_base_reg;
	reg  [11:0] mem_addr_reg;
	reg  [11:0] eff_addr_reg;
	reg  [7:0]  operand_reg;
	reg  [7:0]  result_reg;
	reg  [4:0]  alu_flags_reg;
	reg         skip_reg;
	reg         illegal_reg;
	reg  [1:0]  cycles_reg;
	reg  [31:0] prdata_reg;
	reg         captured_reg;
	reg  [11:0] eff_addr_next;
	reg  [31:0] rd_next;
	reg         mapped;

	wire        increment_reg_op;
	wire        increment_skip_zero_op;
	wire        increment_skip_nonzero_op;
	wire        dest_file;
	wire        bank_sel_mode;
	wire [7:0]  file_addr;
	wire [7:0]  alu_result;
	wire [4:0]  alu_flags;
	wire        apb_done;
	wire        apb_wr;
	wire        core_idle;
	wire        any_op;

	incr_decode u_decode (
		.instr           (instr_reg),
		.is_inc          (increment_reg_op),
		.is_skip_zero    (increment_skip_zero_op),
		.is_skip_nonzero (increment_skip_nonzero_op),
		.dest_file       (dest_file),
		.bank_sel_mode   (bank_sel_mode),
		.file_addr       (file_addr)
	);

	incr_alu u_alu (
		.operand (operand_reg),
		.result  (alu_result),
		.flags   (alu_flags)
	);

	assign any_op = increment_reg_op | increment_skip_zero_op |
		increment_skip_nonzero_op;
	assign core_idle = (state_reg == ST_IDLE);

	// Bus handshake; a frozen clock enable stretches the access phase
	assign pready   = penable & captured_reg & ce;
	assign apb_done = psel & penable & pready;
	assign apb_wr   = apb_done & pwrite;
	// Error rides on pready, so a stalled access never shows it alone
	assign pslverr  = pready & ~mapped;
	assign prdata   = prdata_reg;

	assign busy       = ~core_idle;
	assign skip_taken = skip_reg;

	// Effective data address of the operand
	always @*
	begin
		eff_addr_next = {bank_select_register, file_addr};
		if (!bank_sel_mode)
		begin
			if (ctrl_reg[`CTRL_EXT_BIT] && (file_addr <= `IDX_LIMIT))
				eff_addr_next = index_base_reg + {4'h0, file_addr};
			// Access bank low half or high page
			else if (file_addr <= `IDX_LIMIT)
				eff_addr_next = {`ACC_LO_BASE, file_addr};
			else
				eff_addr_next = {`ACC_HI_BASE, file_addr};
		end
	end

	// Register read mux and address decode
	always @*
	begin
		rd_next = 32'h0000_0000;
		mapped  = 1'b1;
		if (paddr == `REG_CTRL)
			rd_next[1:0] = ctrl_reg;
		else if (paddr == `REG_BANK_SEL)
			rd_next[3:0] = bank_select_register;
		else if (paddr == `REG_WREG)
			rd_next[7:0] = wreg_reg;
		else if (paddr == `REG_FLAGS)
			rd_next[4:0] = flags_reg;
		else if (paddr == `REG_INSTR)
			rd_next[15:0] = instr_reg;
		else if (paddr == `REG_STATUS)
		begin
			rd_next[`STAT_BUSY_BIT] = ~core_idle;
			rd_next[`STAT_SKIP_BIT] = skip_reg;
			rd_next[`STAT_ILL_BIT]  = illegal_reg;
			rd_next[`STAT_CYC_LSB+1:`STAT_CYC_LSB] = cycles_reg;
		end
		else if (paddr == `REG_INDEX_BASE)
			rd_next[11:0] = index_base_reg;
		else if (paddr == `REG_MEM_ADDR)
			rd_next[11:0] = mem_addr_reg;
		else if (paddr == `REG_MEM_DATA)
			rd_next[7:0] = mem[mem_addr_reg];
		else
			mapped = 1'b0;
	end

	// Read data is captured once per transfer so pready can follow at once
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_reg   <= 32'h0000_0000;
			captured_reg <= 1'b0;
		end
		else if (ce)
		begin
			if (apb_done)
				captured_reg <= 1'b0;
			else if (psel && !captured_reg)
			begin
				prdata_reg   <= rd_next;
				captured_reg <= 1'b1;
			end
		end
	end

	// Data memory: core writes in its write phase, bus writes only when idle
	always @(posedge pclk)
	begin
		if (ce)
		begin
			// Write back to the file register
			if ((state_reg == ST_Q4) && dest_file)
				mem[eff_addr_reg] <= result_reg;
			else if (apb_wr && core_idle && (paddr == `REG_MEM_DATA))
				mem[mem_addr_reg] <= pwdata[7:0];
		end
	end

	// Software registers and the four-phase sequencer
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg            <= ST_IDLE;
			nop_phase_reg        <= `RST_CYC;
			nops_left_reg        <= `RST_CYC;
			ctrl_reg             <= `RST_CTRL;
			bank_select_register <= `RST_BANK;
			wreg_reg             <= `RST_BYTE;
			flags_reg            <= `RST_FLAGS;
			instr_reg            <= `RST_INSTR;
			index_base_reg       <= `RST_ADDR;
			mem_addr_reg         <= `RST_ADDR;
			eff_addr_reg         <= `RST_ADDR;
			operand_reg          <= `RST_BYTE;
			result_reg           <= `RST_BYTE;
			alu_flags_reg        <= `RST_FLAGS;
			skip_reg             <= 1'b0;
			illegal_reg          <= 1'b0;
			cycles_reg           <= `RST_CYC;
		end
		else if (ce)
		begin
			// Writes to state the core uses are ignored while it runs
			if (apb_wr && core_idle)
			begin
				if (paddr == `REG_CTRL)
					ctrl_reg <= pwdata[1:0];
				else if (paddr == `REG_BANK_SEL)
					bank_select_register <= pwdata[3:0];
				else if (paddr == `REG_WREG)
					wreg_reg <= pwdata[7:0];
				else if (paddr == `REG_FLAGS)
					flags_reg <= pwdata[4:0];
				else if (paddr == `REG_INDEX_BASE)
					index_base_reg <= pwdata[11:0];
				else if (paddr == `REG_MEM_ADDR)
					mem_addr_reg <= pwdata[11:0];
				else if (paddr == `REG_INSTR)
				begin
					instr_reg   <= pwdata[15:0];
					skip_reg    <= 1'b0;
					illegal_reg <= 1'b0;
					cycles_reg  <= `RST_CYC;
					state_reg   <= ST_Q1;
				end
			end
			// Idle is left to the bus write above; no branch here may touch it
			case (state_reg)
				ST_Q1:
				begin
					eff_addr_reg <= eff_addr_next;
					if (any_op)
						state_reg <= ST_Q2;
					else
					begin
						illegal_reg <= 1'b1;
						state_reg   <= ST_IDLE;
					end
				end
				ST_Q2:
				begin
					operand_reg <= mem[eff_addr_reg];
					state_reg   <= ST_Q3;
				end
				ST_Q3:
				begin
					result_reg    <= alu_result;
					alu_flags_reg <= alu_flags;
					state_reg     <= ST_Q4;
				end
				ST_Q4:
				begin
					cycles_reg <= `ONE_CYC;
					if (!dest_file)
						wreg_reg <= result_reg;
					// Flags only for the plain increment
					if (increment_reg_op)
						flags_reg <= alu_flags_reg;
					if ((increment_skip_zero_op && alu_flags_reg[`FLAG_Z_BIT]) ||
						(increment_skip_nonzero_op && !alu_flags_reg[`FLAG_Z_BIT]))
					begin
						skip_reg      <= 1'b1;
						nop_phase_reg <= `RST_CYC;
						nops_left_reg <= ctrl_reg[`CTRL_TWO_WORD_BIT] ?
							`TWO_NOPS : `ONE_NOP;
						state_reg     <= ST_NOP;
					end
					else
						state_reg <= ST_IDLE;
				end
				ST_NOP:
				begin
					// Four idle phases per discarded cycle
					nop_phase_reg <= nop_phase_reg + 2'h1;
					if (nop_phase_reg == `LAST_PHASE)
					begin
						cycles_reg    <= cycles_reg + 2'h1;
						nops_left_reg <= nops_left_reg - 2'h1;
						if (nops_left_reg == `ONE_NOP)
							state_reg <= ST_IDLE;
					end
				end
				default:
				begin
					// Idle keeps a fresh start; a stray code falls back to idle
					if (!core_idle)
						state_reg <= ST_IDLE;
				end
			endcase
		end
	end

endmodule

// >>> logic/incr_core_map.vh
`ifndef INCR_CORE_MAP_VH
`define INCR_CORE_MAP_VH

// Opcode fields
`define OPC_HI_RANGE      15:12
`define OPC_LO_RANGE      11:10
`define OPC_D_BIT         9
`define OPC_A_BIT         8
`define OPC_F_RANGE       7:0
`define OPC_INC_HI        4'h2
`define OPC_INC_LO        2'h2
`define OPC_ISZ_HI        4'h3
`define OPC_ISZ_LO        2'h3
`define OPC_ISNZ_HI       4'h4
`define OPC_ISNZ_LO       2'h2

// Addressing
`define IDX_LIMIT         8'h5f
`define ACC_HI_BASE       4'hf
`define ACC_LO_BASE       4'h0
`define MEM_DEPTH         4096

// Register byte offsets
`define REG_CTRL          8'h00
`define REG_BANK_SEL      8'h04
`define REG_WREG          8'h08
`define REG_FLAGS         8'h0c
`define REG_INSTR         8'h10
`define REG_STATUS        8'h14
`define REG_INDEX_BASE    8'h18
`define REG_MEM_ADDR      8'h1c
`define REG_MEM_DATA      8'h20

// Field positions and reset values
`define CTRL_EXT_BIT      0
`define CTRL_TWO_WORD_BIT 1
`define FLAG_C_BIT        0
`define FLAG_DIGIT_BIT    1
`define FLAG_Z_BIT        2
`define FLAG_OVF_BIT      3
`define FLAG_N_BIT        4
`define STAT_BUSY_BIT     0
`define STAT_SKIP_BIT     1
`define STAT_ILL_BIT      2
`define STAT_CYC_LSB      4
`define RST_BYTE          8'h00
`define RST_ADDR          12'h000
`define RST_FLAGS         5'h00
`define RST_CTRL          2'h0
`define RST_BANK          4'h0
`define RST_INSTR         16'h0000
`define LAST_PHASE        2'h3
`define RST_CYC           2'h0
`define ONE_CYC           2'h1
`define TWO_NOPS          2'h2
`define ONE_NOP           2'h1

`endif

// >>> logic/incr_decode.v
`include "incr_core_map.vh"

module incr_decode (
	// Instruction word
	input  wire [15:0] instr,
	// Decoded fields
	output wire        is_inc,
	output wire        is_skip_zero,
	output wire        is_skip_nonzero,
	output wire        dest_file,
	output wire        bank_sel_mode,
	output wire [7:0]  file_addr
);

	assign is_inc = (instr[`OPC_HI_RANGE] == `OPC_INC_HI) &&
		(instr[`OPC_LO_RANGE] == `OPC_INC_LO);
	assign is_skip_zero = (instr[`OPC_HI_RANGE] == `OPC_ISZ_HI) &&
		(instr[`OPC_LO_RANGE] == `OPC_ISZ_LO);
	assign is_skip_nonzero = (instr[`OPC_HI_RANGE] == `OPC_ISNZ_HI) &&
		(instr[`OPC_LO_RANGE] == `OPC_ISNZ_LO);

	// Operand fields shared by all three forms
	assign dest_file     = instr[`OPC_D_BIT];
	assign bank_sel_mode = instr[`OPC_A_BIT];
	assign file_addr     = instr[`OPC_F_RANGE];

endmodule
